// *** logic/tst_pkg.sv ***
// shared constants for the two-wire slave transmitter and its bus master
package tst_pkg;
  // device software port
  localparam int          SW_AW          = 3;
  localparam logic [2:0]  DEV_A_CTRL     = 3'h0;
  localparam logic [2:0]  DEV_A_STAT     = 3'h1;
  localparam logic [2:0]  DEV_A_DATA     = 3'h2;
  localparam logic [2:0]  DEV_A_OWN      = 3'h3;
  // control_register fields
  localparam int          CB_DONE        = 7;
  localparam int          CB_ACKEN       = 6;
  localparam int          CB_START       = 5;
  localparam int          CB_STOP        = 4;
  localparam int          CB_EN          = 2;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam logic [7:0]  OWN_RST        = 8'h00;
  localparam logic [7:0]  DATA_RST       = 8'h00;
  localparam logic [1:0]  PRESC_RST      = 2'h0;
  // status codes, prescaler bits masked
  localparam logic [7:0]  CODE_OWN_READ  = 8'hA8;
  localparam logic [7:0]  CODE_ARB_READ  = 8'hB0;
  localparam logic [7:0]  CODE_DATA_ACK  = 8'hB8;
  localparam logic [7:0]  CODE_DATA_NACK = 8'hC0;
  localparam logic [7:0]  CODE_LAST_ACK  = 8'hC8;
  localparam logic [7:0]  CODE_NO_INFO   = 8'hF8;
  localparam logic [7:0]  CODE_BUS_ERR   = 8'h00;
  localparam logic [7:0]  CODE_START_OUT = 8'h08;
  // host software port
  localparam logic [2:0]  H_A_CFG        = 3'h0;
  localparam logic [2:0]  H_A_WDATA      = 3'h1;
  localparam logic [2:0]  H_A_COUNT      = 3'h2;
  localparam logic [2:0]  H_A_GO_STAT    = 3'h3;
  localparam logic [2:0]  H_A_RX         = 3'h4;
  // timing
  localparam int          CLK_NS         = 25;
  localparam int          START_HOLD_NS  = 4000;
  localparam int          START_HOLD_CYC =
    (START_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SCL_PERIOD_NS  = 10000;
  localparam int          QUARTER_CYC    = SCL_PERIOD_NS / 4 / CLK_NS;
endpackage : tst_pkg

// *** logic/tst_link_if.sv ***
// open-drain two-wire link joining device end and bus master end
`timescale 1ns/1ps
interface tst_link_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl;
  logic sda;

  // wired-and with pull-up
  assign scl = !((dev_scl_oe && !dev_scl_o) || (host_scl_oe && !host_scl_o));
  assign sda = !((dev_sda_oe && !dev_sda_o) || (host_sda_oe && !host_sda_o));

  modport dev (output dev_scl_o, output dev_scl_oe, output dev_sda_o,
               output dev_sda_oe, input scl, input sda);
  modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
                output host_sda_oe, input scl, input sda);
endinterface : tst_link_if

// *** logic/tst_dev.sv ***
// slave transmitter, status codes and bus-error recovery of the device end
// Contract
// - own address read acked: flag, code A8
// - lost start then addressed: code B0
// - data byte acked: code B8, wait
// - load byte, ack-enable 0: last byte
// - load byte, ack-enable 1: transfer continues
// - data nacked: code C0, then unaddressed
// - last byte acked: code C8, then unaddressed
// - ack-enable gates own address recognition
// - start request after C0/C8: START later
// - flag clear: status reads F8
// - software idles during no-information state
// - START/STOP inside frame: bus error 00
// - bus error sets job-done flag
// - recovery: stop 1, flag 1, start 0
// - recovery: unaddressed, stop cleared, rest kept
// - recovery releases lines, sends no STOP
// - own START keeps bus until stopped
// - master keeps bus for write-then-read
// - status: five bits high, prescaler low
// - flag set stretches SCL low; code holds it after A8, B0, B8 and 08 only
// - own address upper seven, bit0 general call; bit0 is ignored, so a general call never matches
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module tst_dev
  import tst_pkg::*;
#(
  parameter int START_HOLD = START_HOLD_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [SW_AW-1:0] sw_addr,
  input  wire logic [7:0]       sw_wdata,
  input  wire logic             sw_wr,
  input  wire logic             sw_rd,
  output logic      [7:0]       sw_rdata,
  tst_link_if.dev               link
);

  if (START_HOLD < 1 || START_HOLD > 4096) begin : g_bad_hold
    $error("tst_dev: START_HOLD out of range");
  end

  typedef enum logic [9:0] {
    S_IDLE   = 10'b00_0000_0001,
    S_ADDR   = 10'b00_0000_0010,
    S_AACK   = 10'b00_0000_0100,
    S_LOAD   = 10'b00_0000_1000,
    S_TX     = 10'b00_0001_0000,
    S_TACK   = 10'b00_0010_0000,
    S_REPORT = 10'b00_0100_0000,
    S_ERR    = 10'b00_1000_0000,
    S_GEN    = 10'b01_0000_0000,
    S_MHOLD  = 10'b10_0000_0000
  } tst_dev_state_e;

  tst_dev_state_e state_r;
  logic           done_r;
  logic           acken_r;
  logic           start_r;
  logic           stop_r;
  logic           en_r;
  logic [1:0]     presc_r;
  logic [7:0]     data_r;
  logic [7:0]     own_r;
  logic [7:0]     code_r;
  logic [7:0]     shift_r;
  logic [3:0]     bitcnt_r;
  logic           last_r;
  logic           arb_r;
  logic           ack_r;
  logic           busy_r;
  logic [12:0]    gen_cnt_r;
  logic           scl_oe_r;
  logic           sda_oe_r;
  logic [7:0]     rdata_r;
  logic           scl_s1_r;
  logic           scl_s2_r;
  logic           scl_d_r;
  logic           sda_s1_r;
  logic           sda_s2_r;
  logic           sda_d_r;

  logic wr_ctrl;
  logic go;
  logic rec;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic in_frame;
  logic addr_match;
  logic [4:0] stat_field;

  ////////////////////////////////////////////////////////////////////////////
  // line sampling

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r  <= 1'b1;
    end else begin
      scl_s1_r <= link.scl;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      sda_s1_r <= link.sda;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
    end
  end

  assign scl_rise  = scl_s2_r && !scl_d_r;
  assign scl_fall  = !scl_s2_r && scl_d_r;
  assign start_det = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
  assign stop_det  = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_r <= 1'b0;
    end else if (start_det) begin
      busy_r <= 1'b1;
    end else if (stop_det) begin
      busy_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  assign wr_ctrl = sw_wr && (sw_addr == DEV_A_CTRL);
  assign go      = wr_ctrl && sw_wdata[CB_DONE] && done_r;
  assign rec     = go && sw_wdata[CB_STOP];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      acken_r <= CTRL_RST[CB_ACKEN];
      start_r <= CTRL_RST[CB_START];
      stop_r  <= CTRL_RST[CB_STOP];
      en_r    <= CTRL_RST[CB_EN];
      presc_r <= PRESC_RST;
      data_r  <= DATA_RST;
      own_r   <= OWN_RST;
    end else if (sw_wr) begin
      unique case (sw_addr)
        DEV_A_CTRL: begin
          acken_r <= sw_wdata[CB_ACKEN];
          start_r <= sw_wdata[CB_START];
          en_r    <= sw_wdata[CB_EN];
          stop_r  <= sw_wdata[CB_STOP] && !rec;
        end
        DEV_A_STAT: presc_r <= sw_wdata[1:0];
        // byte only taken while the engine waits, never mid-shift
        DEV_A_DATA: if (done_r) data_r <= sw_wdata;
        DEV_A_OWN:  own_r <= sw_wdata;
        default: ;
      endcase
    end
  end

  assign stat_field = done_r ? code_r[7:3] : CODE_NO_INFO[7:3];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
    end else if (sw_rd) begin
      unique case (sw_addr)
        DEV_A_CTRL: rdata_r <= {done_r, acken_r, start_r, stop_r,
                                1'b0, en_r, 2'b00};
        DEV_A_STAT: rdata_r <= {stat_field, 1'b0, presc_r};
        DEV_A_DATA: rdata_r <= data_r;
        DEV_A_OWN:  rdata_r <= own_r;
        default:    rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign sw_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // transfer engine

  assign in_frame = (state_r == S_AACK) || (state_r == S_TX) ||
                    (state_r == S_TACK) ||
                    ((state_r == S_ADDR) && (bitcnt_r != 4'd0));

  // upper seven bits address, read direction only
  assign addr_match = acken_r && en_r && shift_r[0] &&
                      (shift_r[7:1] == own_r[7:1]);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r   <= S_IDLE;
      done_r    <= CTRL_RST[CB_DONE];
      code_r    <= CODE_NO_INFO;
      shift_r   <= 8'h00;
      bitcnt_r  <= 4'd0;
      last_r    <= 1'b0;
      arb_r     <= 1'b0;
      ack_r     <= 1'b0;
      gen_cnt_r <= 13'd0;
      scl_oe_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
    end else begin
      // later sets in this block override, so a set beats the clear
      if (go) done_r <= 1'b0;
      if (rec && done_r) begin
        state_r  <= S_IDLE;
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else if ((start_det || stop_det) && in_frame) begin
        state_r  <= S_ERR;
        code_r   <= CODE_BUS_ERR;
        done_r   <= 1'b1;
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else begin
        unique case (state_r)
          S_IDLE: begin
            if (start_det) begin
              state_r  <= S_ADDR;
              bitcnt_r <= 4'd0;
              // a START from elsewhere beat our pending request
              arb_r    <= start_r;
            end else if (start_r && en_r && !busy_r) begin
              state_r   <= S_GEN;
              sda_oe_r  <= 1'b1;
              gen_cnt_r <= 13'd0;
            end
          end
          S_ADDR: begin
            if (start_det) begin
              bitcnt_r <= 4'd0;
            end else if (stop_det) begin
              state_r <= S_IDLE;
            end else if (scl_rise) begin
              shift_r  <= {shift_r[6:0], sda_s2_r};
              bitcnt_r <= bitcnt_r + 4'd1;
            end else if (scl_fall && bitcnt_r == 4'd8) begin
              if (addr_match) begin
                state_r  <= S_AACK;
                sda_oe_r <= 1'b1;
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              scl_oe_r <= 1'b1;
              done_r   <= 1'b1;
              state_r  <= S_LOAD;
              code_r   <= arb_r ? CODE_ARB_READ : CODE_OWN_READ;
            end
          end
          S_LOAD: begin
            // SCL held low until flag cleared
            if (go) begin
              last_r   <= !sw_wdata[CB_ACKEN];
              shift_r  <= data_r;
              sda_oe_r <= !data_r[7];
              scl_oe_r <= 1'b0;
              bitcnt_r <= 4'd0;
              state_r  <= S_TX;
            end
          end
          S_TX: begin
            if (scl_fall) begin
              bitcnt_r <= bitcnt_r + 4'd1;
              if (bitcnt_r == 4'd7) begin
                sda_oe_r <= 1'b0;
                state_r  <= S_TACK;
              end else begin
                shift_r  <= {shift_r[6:0], 1'b0};
                sda_oe_r <= !shift_r[6];
              end
            end
          end
          S_TACK: begin
            if (scl_rise) begin
              ack_r <= !sda_s2_r;
            end else if (scl_fall) begin
              done_r <= 1'b1;
              if (ack_r && !last_r) begin
                code_r   <= CODE_DATA_ACK;
                scl_oe_r <= 1'b1;
                state_r  <= S_LOAD;
              end else if (ack_r) begin
                code_r  <= CODE_LAST_ACK;
                state_r <= S_REPORT;
              end else begin
                code_r  <= CODE_DATA_NACK;
                state_r <= S_REPORT;
              end
            end
          end
          S_REPORT: begin
            // master clocking on now reads released SDA as ones
            if (go) state_r <= S_IDLE;
          end
          S_ERR: begin
            state_r <= S_ERR;
          end
          S_GEN: begin
            gen_cnt_r <= gen_cnt_r + 13'd1;
            if (gen_cnt_r == 13'(START_HOLD - 1)) begin
              scl_oe_r <= 1'b1;
              done_r   <= 1'b1;
              code_r   <= CODE_START_OUT;
              state_r  <= S_MHOLD;
            end
          end
          S_MHOLD: begin
            // both lines held until software stops
            state_r <= S_MHOLD;
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

  assign link.dev_scl_o  = 1'b0;
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_scl_oe = scl_oe_r;
  assign link.dev_sda_oe = sda_oe_r;

endmodule : tst_dev

// *** logic/tst_host.sv ***
// bus master receiver end: makes SCL, addresses the device, reads bytes
`timescale 1ns/1ps
module tst_host
  import tst_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [SW_AW-1:0] sw_addr,
  input  wire logic [7:0]       sw_wdata,
  input  wire logic             sw_wr,
  input  wire logic             sw_rd,
  output logic      [7:0]       sw_rdata,
  tst_link_if.host              link
);

  if (QUARTER < 4 || QUARTER > 4096) begin : g_bad_quarter
    $error("tst_host: QUARTER out of range");
  end

  typedef enum logic [3:0] {
    H_IDLE   = 4'b0001,
    H_LAUNCH = 4'b0010,
    H_RUN    = 4'b0100,
    H_HOLDRX = 4'b1000
  } tst_host_state_e;

  typedef enum logic [6:0] {
    P_START  = 7'b000_0001,
    P_ADDRW  = 7'b000_0010,
    P_WDATA  = 7'b000_0100,
    P_RSTART = 7'b000_1000,
    P_ADDRR  = 7'b001_0000,
    P_READ   = 7'b010_0000,
    P_STOP   = 7'b100_0000
  } tst_host_step_e;

  tst_host_state_e state_r;
  tst_host_step_e  step_r;
  logic [6:0]      addr_r;
  logic            wrf_r;
  logic [7:0]      wbyte_r;
  logic [7:0]      count_r;
  logic [7:0]      left_r;
  logic            busy_r;
  logic            anack_r;
  logic            dnack_r;
  logic [7:0]      rx_r;
  logic            rxfull_r;
  logic [8:0]      shift_r;
  logic [8:0]      in_r;
  logic [1:0]      q_r;
  logic [11:0]     qc_r;
  logic [3:0]      bit_r;
  logic            scl_oe_r;
  logic            sda_oe_r;
  logic [7:0]      rdata_r;
  logic            scl_s1_r;
  logic            scl_s2_r;
  logic            sda_s1_r;
  logic            sda_s2_r;

  logic is_start;
  logic is_stop;
  logic q_end;
  logic go;
  logic rx_take;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      scl_s1_r <= link.scl;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= link.sda;
      sda_s2_r <= sda_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  assign go      = sw_wr && (sw_addr == H_A_GO_STAT) && !busy_r;
  assign rx_take = sw_rd && (sw_addr == H_A_RX);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addr_r  <= 7'h00;
      wrf_r   <= 1'b0;
      wbyte_r <= 8'h00;
      count_r <= 8'h00;
    end else if (sw_wr && !busy_r) begin
      unique case (sw_addr)
        H_A_CFG:   {addr_r, wrf_r} <= sw_wdata;
        H_A_WDATA: wbyte_r <= sw_wdata;
        H_A_COUNT: count_r <= sw_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
    end else if (sw_rd) begin
      unique case (sw_addr)
        H_A_GO_STAT: rdata_r <= {4'h0, dnack_r, rxfull_r, anack_r, busy_r};
        H_A_RX:      rdata_r <= rx_r;
        default:     rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign sw_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // slot engine: four quarters per bit, START or STOP

  assign is_start = (step_r == P_START) || (step_r == P_RSTART);
  assign is_stop  = (step_r == P_STOP);
  // quarter 1 waits for SCL high, so a stretching slave pauses us
  assign q_end    = (qc_r == 12'(QUARTER - 1)) && (q_r != 2'd1 || scl_s2_r);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r  <= H_IDLE;
      step_r   <= P_START;
      left_r   <= 8'h00;
      busy_r   <= 1'b0;
      anack_r  <= 1'b0;
      dnack_r  <= 1'b0;
      rx_r     <= 8'h00;
      rxfull_r <= 1'b0;
      shift_r  <= 9'h000;
      in_r     <= 9'h000;
      q_r      <= 2'd0;
      qc_r     <= 12'd0;
      bit_r    <= 4'd0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      if (rx_take) rxfull_r <= 1'b0;
      unique case (state_r)
        H_IDLE: begin
          if (go) begin
            busy_r  <= 1'b1;
            anack_r <= 1'b0;
            dnack_r <= 1'b0;
            left_r  <= count_r;
            step_r  <= P_START;
            state_r <= H_LAUNCH;
          end
        end
        H_LAUNCH: begin
          q_r      <= 2'd0;
          qc_r     <= 12'd0;
          state_r  <= H_RUN;
          sda_oe_r <= is_start ? 1'b0 : (is_stop ? 1'b1 : !shift_r[8]);
        end
        H_RUN: begin
          qc_r <= (qc_r == 12'(QUARTER - 1)) ? qc_r : qc_r + 12'd1;
          if (q_end) begin
            qc_r <= 12'd0;
            q_r  <= q_r + 2'd1;
            unique case (q_r)
              2'd0: scl_oe_r <= 1'b0;
              2'd1: begin
                if (is_start) sda_oe_r <= 1'b1;
                else if (is_stop) sda_oe_r <= 1'b0;
                else in_r <= {in_r[7:0], sda_s2_r};
              end
              2'd2: if (!is_stop) scl_oe_r <= 1'b1;
              default: begin
                state_r <= H_LAUNCH;
                bit_r   <= 4'd0;
                if (is_stop) begin
                  state_r <= H_IDLE;
                  busy_r  <= 1'b0;
                end else if (is_start) begin
                  step_r  <= (step_r == P_START && wrf_r) ? P_ADDRW : P_ADDRR;
                  shift_r <= {addr_r,
                              !(step_r == P_START && wrf_r), 1'b1};
                end else if (bit_r != 4'd8) begin
                  bit_r   <= bit_r + 4'd1;
                  shift_r <= {shift_r[7:0], 1'b1};
                end else begin
                  unique case (step_r)
                    P_ADDRW: begin
                      anack_r <= in_r[0];
                      step_r  <= in_r[0] ? P_STOP : P_WDATA;
                      shift_r <= {wbyte_r, 1'b1};
                    end
                    P_WDATA: begin
                      dnack_r <= in_r[0];
                      step_r  <= P_RSTART;
                    end
                    P_ADDRR: begin
                      anack_r <= in_r[0];
                      step_r  <= (in_r[0] || left_r == 8'h00) ?
                                 P_STOP : P_READ;
                      shift_r <= {8'hFF, left_r == 8'h01};
                    end
                    default: begin
                      rx_r     <= in_r[8:1];
                      rxfull_r <= 1'b1;
                      left_r   <= left_r - 8'h01;
                      state_r  <= H_HOLDRX;
                    end
                  endcase
                end
              end
            endcase
          end
        end
        H_HOLDRX: begin
          // SCL stays low until software has taken the byte
          if (!rxfull_r) begin
            step_r  <= (left_r == 8'h00) ? P_STOP : P_READ;
            shift_r <= {8'hFF, left_r == 8'h01};
            state_r <= H_LAUNCH;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign link.host_scl_o  = 1'b0;
  assign link.host_sda_o  = 1'b0;
  assign link.host_scl_oe = scl_oe_r;
  assign link.host_sda_oe = sda_oe_r;

endmodule : tst_host

// *** dv/tst_link_monitor.sv ***
// concurrent checks on the shared two-wire link
`timescale 1ns/1ps
module tst_link_monitor (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  //////////////////////////////
  // device claims the bus: sda pulled while scl high
  sequence claim_s; $rose(dev_sda_oe) && scl; endsequence
  sequence hold_s; dev_sda_oe [*4]; endsequence
  start_free_a: assert property (
    claim_s |-> $past(sda) && !host_sda_oe)
    else $error("device start on a busy bus");
  start_hold_a: assert property (claim_s |-> hold_s)
    else $error("device let go of the bus after start");
  // stretch begins once scl is already low, or while the device holds sda after its own start
  stretch_begin_a: assert property (
    $rose(dev_scl_oe) |-> $past(!scl) || dev_sda_oe)
    else $error("device pulled scl while high");
  stretch_low_a: assert property (dev_scl_oe |-> !scl)
    else $error("scl high while device stretches");
  dev_drain_a: assert property (!dev_scl_o && !dev_sda_o)
    else $error("device drives a line high");
  host_drain_a: assert property (!host_scl_o && !host_sda_o)
    else $error("host drives a line high");
  scl_wire_a: assert property (
    scl == !(dev_scl_oe || host_scl_oe))
    else $error("scl level wrong");
  sda_wire_a: assert property (
    sda == !(dev_sda_oe || host_sda_oe))
    else $error("sda level wrong");
endmodule : tst_link_monitor

// *** dv/tst_test.sv ***
// bench: device end and bus master end joined on one link
`timescale 1ns/1ps
module tst_test;
  import tst_pkg::*;
  localparam logic [6:0] ADR = 7'h5A;
  logic        sys_clk, srst, dwr, drd, hwr, hrd;
  logic [2:0]  ad;
  logic [7:0]  wd, dq, hq, b, q;
  logic [31:0] s;
  int          fail_count, n_compared, n, k;
  tst_link_if link ();
  tst_dev #(.START_HOLD(4)) tst_dev_i (.sys_clk(sys_clk), .srst(srst),
    .sw_addr(ad), .sw_wdata(wd), .sw_wr(dwr), .sw_rd(drd),
    .sw_rdata(dq), .link(link));
  tst_host #(.QUARTER(8)) tst_host_i (.sys_clk(sys_clk), .srst(srst),
    .sw_addr(ad), .sw_wdata(wd), .sw_wr(hwr), .sw_rd(hrd),
    .sw_rdata(hq), .link(link));
  tst_link_monitor tst_link_monitor_i (.sys_clk(sys_clk), .srst(srst),
    .dev_scl_o(link.dev_scl_o), .dev_scl_oe(link.dev_scl_oe),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .host_scl_o(link.host_scl_o), .host_scl_oe(link.host_scl_oe),
    .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
    .scl(link.scl), .sda(link.sda));
  //////////////////////////////
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] a);
    n_compared++;
    if (a !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, a);
    end
  endtask : chk
  task automatic wr(input bit h, input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    ad <= a; wd <= d; dwr <= !h; hwr <= h;
    @(posedge sys_clk);
    dwr <= 1'b0; hwr <= 1'b0;
  endtask : wr
  task automatic rd(input bit h, input logic [2:0] a, output logic [7:0] r);
    @(posedge sys_clk);
    ad <= a; drd <= !h; hrd <= h;
    @(posedge sys_clk);
    drd <= 1'b0; hrd <= 1'b0;
    @(negedge sys_clk);
    r = h ? hq : dq;
  endtask : rd
  task automatic rc(input bit h, input logic [2:0] a, input logic [7:0] e);
    rd(h, a, q);
    chk(h ? "host_reg" : "dev_reg", e, q);
  endtask : rc
  // bounded wait for one bit of a register to reach v
  task automatic poll(input bit h, input logic [2:0] a, input int i, input bit v);
    logic [7:0] r;
    int t;
    t = 0;
    do begin
      rd(h, a, r);
      t++;
    end while (r[i] !== v && t < 3000);
    chk("poll_bit", {7'h0, v}, {7'h0, r[i]});
  endtask : poll
  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  //////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    #2_000_000;
    fail_count++;
    print_verdict();
  end
  initial begin
    s = 24; srst = 1'b1; ad = 3'h0; wd = 8'h00;
    dwr = 1'b0; drd = 1'b0; hwr = 1'b0; hrd = 1'b0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rc(0, DEV_A_STAT, 8'hF8);
    rc(0, DEV_A_CTRL, 8'h00);
    wr(0, DEV_A_STAT, 8'h03);
    rc(0, DEV_A_STAT, 8'hFB);
    rc(0, 3'h7, 8'h00);
    wr(0, DEV_A_STAT, 8'h00);
    wr(0, DEV_A_OWN, {ADR, 1'b1});
    wr(0, DEV_A_CTRL, 8'h44);
    wr(1, H_A_CFG, {ADR, 1'b0});
    // pass 0 ends on a nack, pass 1 on an unwanted ack
    for (int p = 0; p < 2; p++) begin
      n = p ? 2 : 1 + rnd() % 3;
      k = p ? 1 : n;
      wr(1, H_A_COUNT, n[7:0]);
      wr(1, H_A_GO_STAT, 8'h01);
      poll(0, DEV_A_CTRL, CB_DONE, 1);
      rc(0, DEV_A_STAT, CODE_OWN_READ);
      for (int i = 0; i < n; i++) begin
        b = (i < k) ? rnd() : 8'hFF;
        if (i < k) wr(0, DEV_A_DATA, b);
        if (i < k) wr(0, DEV_A_CTRL, (i == k - 1) ? 8'h84 : 8'hC4);
        poll(1, H_A_GO_STAT, 2, 1);
        rc(1, H_A_RX, b);
        if (i < k) poll(0, DEV_A_CTRL, CB_DONE, 1);
        if (i < k) rc(0, DEV_A_STAT, (i < k - 1) ? CODE_DATA_ACK :
          p ? CODE_LAST_ACK : CODE_DATA_NACK);
        if (i == k - 1) wr(0, DEV_A_CTRL, p ? 8'hC4 : 8'hE4);
      end
      poll(1, H_A_GO_STAT, 0, 0);
      if (!p) poll(0, DEV_A_CTRL, CB_DONE, 1);
      if (!p) rc(0, DEV_A_STAT, CODE_START_OUT);
      if (!p) wr(0, DEV_A_CTRL, 8'hD4);
      if (!p) rc(0, DEV_A_CTRL, 8'h44);
      repeat (4) @(posedge sys_clk);
      // look between edges, once the released lines have settled
      @(negedge sys_clk);
      chk("lines", 8'h03, {6'h0, link.scl, link.sda});
    end
    // own address ignored while acknowledge is off
    wr(0, DEV_A_CTRL, 8'h04);
    wr(1, H_A_COUNT, 8'h01);
    wr(1, H_A_GO_STAT, 8'h01);
    poll(1, H_A_GO_STAT, 0, 0);
    poll(1, H_A_GO_STAT, 1, 1);
    rc(0, DEV_A_STAT, CODE_NO_INFO);
    // stop inside a data byte, then recovery
    wr(0, DEV_A_CTRL, 8'h44);
    wr(1, H_A_COUNT, 8'h00);
    wr(1, H_A_GO_STAT, 8'h01);
    poll(0, DEV_A_CTRL, CB_DONE, 1);
    wr(0, DEV_A_DATA, 8'h80 | rnd());
    wr(0, DEV_A_CTRL, 8'hC4);
    poll(0, DEV_A_CTRL, CB_DONE, 1);
    rc(0, DEV_A_STAT, CODE_BUS_ERR);
    wr(0, DEV_A_CTRL, 8'hD4);
    rc(0, DEV_A_CTRL, 8'h44);
    rc(0, DEV_A_STAT, CODE_NO_INFO);
    poll(1, H_A_GO_STAT, 0, 0);
    chk("lines", 8'h03, {6'h0, link.scl, link.sda});
    print_verdict();
  end
endmodule : tst_test
